// ---- logic/pclc_pkg.sv ----
// Constants and carrier types of the program counter and loop control
package pclc_pkg;
  localparam int          PC_W        = 23;
  localparam int          TGT_W       = 24;
  localparam int          CNT_W       = 16;
  localparam int          BASE_CNT_W  = 14;
  localparam int          EXT_LIT_W   = 15;
  localparam int          EXT_DEPTH   = 4;
  localparam int          BASE_DEPTH  = 1;
  localparam logic [23:0] PC_LIMIT    = 24'h800000;
  localparam logic [22:0] PC_STEP     = 23'h000002;
  localparam logic [22:0] PC_ALIGN    = 23'h7FFFFE;
  localparam logic [15:0] BASE_MASK   = 16'h3FFF;
  localparam logic [15:0] LIT_MASK    = 16'h7FFF;
  localparam logic [15:0] FULL_MASK   = 16'hFFFF;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [2:0]  NEST_ONE    = 3'h1;
  localparam logic [2:0]  NEST_MAX    = 3'h7;
  // Register indices
  localparam logic [3:0]  REP_CNT_OFS = 4'h0;
  localparam logic [3:0]  HWL_CNT_OFS = 4'h1;
  localparam logic [3:0]  START_L_OFS = 4'h2;
  localparam logic [3:0]  START_H_OFS = 4'h3;
  localparam logic [3:0]  END_L_OFS   = 4'h4;
  localparam logic [3:0]  END_H_OFS   = 4'h5;
  localparam logic [3:0]  STATUS_OFS  = 4'h6;
  localparam logic [3:0]  CORE_OFS    = 4'h7;
  localparam logic [3:0]  PC_L_OFS    = 4'h8;
  localparam logic [3:0]  PC_H_OFS    = 4'h9;
  // Field positions
  localparam int          REP_ACT_BIT = 4;
  localparam int          HWL_ACT_BIT = 9;
  localparam int          EARLY_BIT   = 11;
  localparam int          NEST_LSB    = 8;
  localparam int          FAULT_BIT   = 0;

  typedef enum logic [1:0] {
    PCLC_SEQ = 2'b01,
    PCLC_REP = 2'b10
  } pclc_mode_type;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [PC_W-1:0]  start;
    logic [PC_W-1:0]  fin;
  } pclc_ctx_type;

  typedef struct packed {
    logic             step;
    logic             trap;
    logic             retfie;
    logic             repeat_op;
    logic             loop_op;
    logic             branch;
    logic             from_reg;
    logic [CNT_W-1:0] operand;
    logic [TGT_W-1:0] target;
    logic [7:0]       status_low;
  } pclc_dec_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pclc_bus_type;
endpackage

// ---- logic/pclc_loop_ctrl.sv ----
// Program counter, single-instruction repeat and hardware loop control
// What this block does
// - PC is 23 bits, bit 0 always zero for word alignment.
// - Sequential execution advances the PC by two per instruction word.
// - PC never fetches at or above the configuration region address.
// - Repeat count is 14 bits on base, 16 bits on extended variant.
// - Repeat loads literal or low 14 register bits; extended uses 15/16.
// - Repeated instruction runs repeat count plus one times.
// - Writing zero to repeat count during suspension stops repeating.
// - Repeat flag sets as target starts, clears after its last run.
// - Repeat flag is read-only; only repeat processing, trap entry and exception return change it.
// - Exception return restores repeat flag; zero cancels repetition.
// - Loop count is 14 bits on base, 16 bits on extended variant.
// - Loop op loads literal or low 14 register bits; extended 15/16.
// - Loop body runs loop count plus one times.
// - Loop start captures address right after the loop instruction.
// - Loop end captures the instruction's end address operand.
// - After the end instruction, fetch returns to start, no extra cycle.
// - Base keeps one shadow context; extended keeps a four-level stack.
// - On extended variant loop start is read-only to software.
// - Loop flag sets at first body instruction, clears after final one.
// - Loop flag is read-only; writes neither start nor stop loops.
// - Early-terminate bit 11 of core configuration ends active loop.
// - Base shadow gives exactly one extra nesting level for free.
// - Extended nesting level counts active loops; the next free stack entry is one below it.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module pclc_loop_ctrl #(
  parameter bit EXTENDED = 1'b0
) (
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  ARST_N_IN,
  input  wire pclc_pkg::pclc_dec_type DEC_IN,
  input  wire pclc_pkg::pclc_bus_type BUS_IN,
  output logic [15:0]                RDATA_OUT,
  output logic [22:0]                PC_OUT,
  output logic                       REPEAT_ACTIVE_OUT,
  output logic                       LOOP_ACTIVE_OUT,
  output logic                       FETCH_FAULT_OUT
);
  import pclc_pkg::*;

  localparam int DEPTH = EXTENDED ? EXT_DEPTH : BASE_DEPTH;
  localparam logic [15:0] REG_MASK = EXTENDED ? FULL_MASK : BASE_MASK;
  localparam logic [15:0] IMM_MASK = EXTENDED ? LIT_MASK : BASE_MASK;

  typedef struct packed {
    pclc_mode_type                mode;
    logic [PC_W-1:0]              pc;
    logic [CNT_W-1:0]             rep_count;
    pclc_ctx_type                 ctx;
    pclc_ctx_type [DEPTH-1:0]     stk;
    logic                         loop_active;
    logic [2:0]                   nest_level;
    logic                         early_term;
    logic                         fault;
    logic [15:0]                  rdata;
  } pclc_state_type;

  logic           sync1_reg;
  logic           rst_n;
  pclc_state_type state_reg;
  pclc_state_type state_next;
  logic [15:0]    count_val;
  logic [22:0]    pc_inc;
  logic           at_end;
  logic [15:0]    status_word;
  logic [15:0]    core_word;

  // Reset release through two flops
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sync1_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      sync1_reg <= 1'b1;
      rst_n     <= sync1_reg;
    end
  end

  assign count_val = DEC_IN.from_reg ? (DEC_IN.operand & REG_MASK)
                                     : (DEC_IN.operand & IMM_MASK);
  assign pc_inc = state_reg.pc + PC_STEP;
  assign at_end = state_reg.loop_active && (state_reg.pc == state_reg.ctx.fin);

  always_comb begin
    status_word              = '0;
    status_word[REP_ACT_BIT] = (state_reg.mode == PCLC_REP);
    status_word[HWL_ACT_BIT] = state_reg.loop_active;
    core_word                = '0;
    core_word[EARLY_BIT]     = state_reg.early_term;
    core_word[NEST_LSB+:3]   = state_reg.nest_level;
    core_word[FAULT_BIT]     = state_reg.fault;
  end

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = '0;
    if (BUS_IN.rd) begin
      case (BUS_IN.addr)
        REP_CNT_OFS: state_next.rdata = state_reg.rep_count;
        HWL_CNT_OFS: state_next.rdata = state_reg.ctx.count;
        START_L_OFS: state_next.rdata = state_reg.ctx.start[15:0];
        START_H_OFS: state_next.rdata = {9'h000, state_reg.ctx.start[22:16]};
        END_L_OFS:   state_next.rdata = state_reg.ctx.fin[15:0];
        END_H_OFS:   state_next.rdata = {9'h000, state_reg.ctx.fin[22:16]};
        STATUS_OFS:  state_next.rdata = status_word;
        CORE_OFS:    state_next.rdata = core_word;
        PC_L_OFS:    state_next.rdata = state_reg.pc[15:0];
        PC_H_OFS:    state_next.rdata = {9'h000, state_reg.pc[22:16]};
        default:     state_next.rdata = '0;
      endcase
    end
    if (BUS_IN.wr) begin
      case (BUS_IN.addr)
        REP_CNT_OFS: state_next.rep_count = BUS_IN.wdata & REG_MASK;
        HWL_CNT_OFS: state_next.ctx.count = BUS_IN.wdata & REG_MASK;
        START_L_OFS: if (!EXTENDED) begin
          state_next.ctx.start[15:0] = BUS_IN.wdata & PC_ALIGN[15:0];
        end
        START_H_OFS: if (!EXTENDED) begin
          state_next.ctx.start[22:16] = BUS_IN.wdata[6:0];
        end
        END_L_OFS:   state_next.ctx.fin[15:0] = BUS_IN.wdata & PC_ALIGN[15:0];
        END_H_OFS:   state_next.ctx.fin[22:16] = BUS_IN.wdata[6:0];
        default:     ;
      endcase
    end
    if (DEC_IN.step) begin
      if (DEC_IN.trap) begin
        state_next.mode = PCLC_SEQ;
        state_next.pc   = DEC_IN.target[22:0] & PC_ALIGN;
      end else if (state_reg.mode == PCLC_REP) begin
        if (state_next.rep_count == '0) begin
          state_next.mode = PCLC_SEQ;
          state_next.pc   = pc_inc;
        end else begin
          state_next.rep_count = state_next.rep_count - CNT_ONE;
        end
      end else if (DEC_IN.retfie) begin
        state_next.mode = DEC_IN.status_low[REP_ACT_BIT] ? PCLC_REP : PCLC_SEQ;
        state_next.pc   = DEC_IN.target[22:0] & PC_ALIGN;
      end else if (DEC_IN.repeat_op) begin
        state_next.rep_count = count_val;
        state_next.mode      = PCLC_REP;
        state_next.pc        = pc_inc;
      end else if (DEC_IN.loop_op) begin
        if (state_reg.loop_active && (state_reg.nest_level <= 3'(DEPTH))) begin
          state_next.stk[state_reg.nest_level - NEST_ONE] = state_next.ctx;
        end
        state_next.ctx.count   = count_val;
        state_next.ctx.start   = pc_inc;
        state_next.ctx.fin     = DEC_IN.target[22:0] & PC_ALIGN;
        state_next.loop_active = 1'b1;
        if (state_reg.nest_level != NEST_MAX) begin
          state_next.nest_level = state_reg.nest_level + NEST_ONE;
        end
        state_next.pc = pc_inc;
      end else if (DEC_IN.branch) begin
        if (DEC_IN.target >= PC_LIMIT) begin
          state_next.fault = 1'b1;
        end else begin
          state_next.pc = DEC_IN.target[22:0] & PC_ALIGN;
        end
      end else if (at_end) begin
        if ((state_next.ctx.count == '0) || state_reg.early_term) begin
          state_next.pc         = pc_inc;
          state_next.early_term = 1'b0;
          state_next.nest_level = state_reg.nest_level - NEST_ONE;
          if ((state_reg.nest_level > NEST_ONE) &&
              (state_reg.nest_level <= 3'(DEPTH + 1))) begin
            state_next.ctx = state_reg.stk[state_reg.nest_level - 3'h2];
          end else begin
            state_next.loop_active = 1'b0;
            state_next.nest_level  = '0;
          end
        end else begin
          state_next.ctx.count = state_next.ctx.count - CNT_ONE;
          state_next.pc        = state_reg.ctx.start;
        end
      end else begin
        state_next.pc = pc_inc;
      end
    end
    // software request; fault set wins over clear
    if (BUS_IN.wr && (BUS_IN.addr == CORE_OFS)) begin
      state_next.early_term = BUS_IN.wdata[EARLY_BIT];
      if (BUS_IN.wdata[FAULT_BIT] && !(DEC_IN.step && DEC_IN.branch &&
          (DEC_IN.target >= PC_LIMIT))) begin
        state_next.fault = 1'b0;
      end
    end
    state_next.pc = state_next.pc & PC_ALIGN;
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= '0;
      state_reg.mode <= PCLC_SEQ;
    end else begin
      state_reg <= state_next;
    end
  end

  assign RDATA_OUT         = state_reg.rdata;
  assign PC_OUT            = state_reg.pc;
  assign REPEAT_ACTIVE_OUT = state_reg.mode[1];
  assign LOOP_ACTIVE_OUT   = state_reg.loop_active;
  assign FETCH_FAULT_OUT   = state_reg.fault;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  logic plain_step;
  assign plain_step = DEC_IN.step && !DEC_IN.trap && !DEC_IN.retfie &&
                      !DEC_IN.repeat_op && !DEC_IN.loop_op && !DEC_IN.branch;

  sequence seq_loop_issue;
    DEC_IN.step && DEC_IN.loop_op && !DEC_IN.trap && !DEC_IN.retfie &&
    (state_reg.mode == PCLC_SEQ);
  endsequence
  sequence seq_loop_loaded;
    LOOP_ACTIVE_OUT && (state_reg.ctx.start == $past(pc_inc)) &&
    (state_reg.ctx.fin == ($past(DEC_IN.target[22:0]) & PC_ALIGN)) &&
    (state_reg.ctx.count == $past(count_val));
  endsequence

  logic core_wr;
  logic start_wr;
  assign core_wr  = BUS_IN.wr && (BUS_IN.addr == CORE_OFS);
  assign start_wr = BUS_IN.wr && ((BUS_IN.addr == START_L_OFS) ||
                                  (BUS_IN.addr == START_H_OFS));
  sequence seq_end_step;
    plain_step && !REPEAT_ACTIVE_OUT && at_end && !BUS_IN.wr;
  endsequence
  sequence seq_rep_zeroed;
    BUS_IN.wr && (BUS_IN.addr == REP_CNT_OFS) && !DEC_IN.step &&
    ((BUS_IN.wdata & REG_MASK) == '0);
  endsequence

  a_pc_aligned: assert property (PC_OUT[0] == 1'b0)
    else $error("PC bit 0 not zero");
  a_pc_step_two: assert property (plain_step && !REPEAT_ACTIVE_OUT && !at_end
    |=> PC_OUT == $past(PC_OUT) + PC_STEP)
    else $error("PC did not advance by two");
  a_no_high_fetch: assert property (DEC_IN.step && DEC_IN.branch &&
    !DEC_IN.trap && !DEC_IN.retfie && !DEC_IN.repeat_op && !DEC_IN.loop_op &&
    !REPEAT_ACTIVE_OUT && DEC_IN.target >= PC_LIMIT
    |=> FETCH_FAULT_OUT && $stable(PC_OUT))
    else $error("PC entered high region");
  a_repeat_load: assert property (DEC_IN.step && DEC_IN.repeat_op &&
    !DEC_IN.trap && !DEC_IN.retfie && !REPEAT_ACTIVE_OUT && !BUS_IN.wr
    |=> REPEAT_ACTIVE_OUT && state_reg.rep_count == $past(count_val))
    else $error("Repeat count not loaded");
  a_repeat_last: assert property (REPEAT_ACTIVE_OUT && DEC_IN.step &&
    !DEC_IN.trap && state_reg.rep_count == '0 && !BUS_IN.wr
    |=> !REPEAT_ACTIVE_OUT ##0 PC_OUT == $past(pc_inc))
    else $error("Repeat did not end");
  a_flags_ro: assert property (BUS_IN.wr && !DEC_IN.step
    |=> $stable(REPEAT_ACTIVE_OUT) && $stable(LOOP_ACTIVE_OUT))
    else $error("Flag changed by write");
  a_loop_load: assert property (seq_loop_issue and !BUS_IN.wr
    |=> seq_loop_loaded)
    else $error("Loop context not captured");
  a_loop_back: assert property (plain_step && !REPEAT_ACTIVE_OUT && at_end &&
    state_reg.ctx.count != '0 && !state_reg.early_term && !BUS_IN.wr
    |=> PC_OUT == $past(state_reg.ctx.start))
    else $error("No return to loop start");
  a_early_exit: assert property (plain_step && !REPEAT_ACTIVE_OUT && at_end &&
    state_reg.early_term && state_reg.nest_level == NEST_ONE && !BUS_IN.wr
    |=> !LOOP_ACTIVE_OUT && PC_OUT == $past(pc_inc))
    else $error("Early exit failed");
  a_rep_width: assert property (
    (state_reg.rep_count & ~REG_MASK) == '0)
    else $error("Repeat count wider than allowed");
  a_loop_width: assert property (
    (state_reg.ctx.count & ~REG_MASK) == '0)
    else $error("Loop count wider than allowed");
  a_rep_hold: assert property (REPEAT_ACTIVE_OUT && DEC_IN.step &&
    !DEC_IN.trap && state_reg.rep_count != '0 && !BUS_IN.wr
    |=> REPEAT_ACTIVE_OUT && $stable(PC_OUT) &&
    state_reg.rep_count == $past(state_reg.rep_count) - CNT_ONE)
    else $error("Repeat did not hold the PC");
  a_rep_zeroed: assert property (seq_rep_zeroed
    |=> state_reg.rep_count == '0)
    else $error("Repeat count write lost");
  a_trap_entry: assert property (DEC_IN.step && DEC_IN.trap
    |=> !REPEAT_ACTIVE_OUT &&
    PC_OUT == ($past(DEC_IN.target[22:0]) & PC_ALIGN))
    else $error("Trap entry wrong");
  a_ret_restore: assert property (DEC_IN.step && DEC_IN.retfie &&
    !DEC_IN.trap && !REPEAT_ACTIVE_OUT
    |=> REPEAT_ACTIVE_OUT == $past(DEC_IN.status_low[REP_ACT_BIT]))
    else $error("Repeat flag not restored");
  a_loop_exit: assert property (seq_end_step and
    (state_reg.ctx.count == '0 && !state_reg.early_term &&
    state_reg.nest_level == NEST_ONE)
    |=> !LOOP_ACTIVE_OUT && PC_OUT == $past(pc_inc))
    else $error("Loop did not finish");
  a_nest_push: assert property (seq_loop_issue and
    (!BUS_IN.wr && LOOP_ACTIVE_OUT && state_reg.nest_level == NEST_ONE)
    |=> state_reg.stk[0] == $past(state_reg.ctx))
    else $error("Outer loop context not saved");
  a_nest_count: assert property (seq_loop_issue and
    (!BUS_IN.wr && state_reg.nest_level != NEST_MAX)
    |=> state_reg.nest_level == $past(state_reg.nest_level) + NEST_ONE)
    else $error("Nesting level not advanced");
  a_nest_pop: assert property (seq_end_step and
    (state_reg.early_term && state_reg.nest_level == 3'h2)
    |=> LOOP_ACTIVE_OUT && state_reg.nest_level == NEST_ONE &&
    state_reg.ctx == $past(state_reg.stk[0]))
    else $error("Outer loop context not restored");
  a_early_clear: assert property (seq_end_step and
    state_reg.early_term |=> !state_reg.early_term)
    else $error("Early terminate not cleared");
  a_early_write: assert property (core_wr
    |=> state_reg.early_term == $past(BUS_IN.wdata[EARLY_BIT]))
    else $error("Early terminate write lost");
  a_start_ro: assert property (EXTENDED && start_wr && !DEC_IN.step
    |=> $stable(state_reg.ctx.start))
    else $error("Loop start written while read-only");
  a_fault_sticky: assert property (FETCH_FAULT_OUT &&
    !(core_wr && BUS_IN.wdata[FAULT_BIT]) |=> FETCH_FAULT_OUT)
    else $error("Fault flag dropped");
  a_reset_idle: assert property ($rose(rst_n) |-> PC_OUT == '0 &&
    !REPEAT_ACTIVE_OUT && !LOOP_ACTIVE_OUT)
    else $error("Block not idle after reset");
endmodule

// ---- test/pclc_fetch_model.sv ----
// Behavioural decode stage that hands instructions to the block
`timescale 1ns/100ps
module pclc_fetch_model (
  input  wire logic                   clk_in,
  output pclc_pkg::pclc_dec_type      dec_out
);
  import pclc_pkg::*;

  initial begin
    dec_out = '0;
  end

  // One step pulse, then idle with operands no longer valid
  task automatic issue(input pclc_dec_type d);
    @(posedge clk_in);
    dec_out <= d;
    @(posedge clk_in);
    dec_out <= {7'h00, ~d.operand, ~d.target, ~d.status_low};
    #1;
  endtask
endmodule

// ---- test/test_program_counter_loop_control.sv ----
// Self-checking bench of the program counter and loop control
`timescale 1ns/100ps
module test_program_counter_loop_control;
  import pclc_pkg::*;
  localparam logic [6:0] K_ST = 7'h40;
  localparam logic [6:0] K_TR = 7'h60;
  localparam logic [6:0] K_RF = 7'h50;
  localparam logic [6:0] K_RP = 7'h48;
  localparam logic [6:0] K_LP = 7'h44;
  localparam logic [6:0] K_BR = 7'h42;
  logic         clk;
  logic         arst_n;
  pclc_dec_type dec;
  pclc_bus_type bus;
  logic [15:0]  rdata;
  logic [15:0]  rdata_x;
  logic [22:0]  pc;
  logic         rep_act;
  logic         loop_act;
  logic         fault;
  int           fails;
  int           samples_checked;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pclc_fetch_model fe (.clk_in(clk), .dec_out(dec));

  pclc_loop_ctrl #(.EXTENDED(1'b0)) dut (
    .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .DEC_IN(dec), .BUS_IN(bus),
    .RDATA_OUT(rdata), .PC_OUT(pc), .REPEAT_ACTIVE_OUT(rep_act),
    .LOOP_ACTIVE_OUT(loop_act), .FETCH_FAULT_OUT(fault)
  );

  pclc_loop_ctrl #(.EXTENDED(1'b1)) dut_ext (
    .CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .DEC_IN(dec), .BUS_IN(bus),
    .RDATA_OUT(rdata_x), .PC_OUT(), .REPEAT_ACTIVE_OUT(),
    .LOOP_ACTIVE_OUT(), .FETCH_FAULT_OUT()
  );

  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pchk(input logic [22:0] e);
    chk("pc", {1'b0, e}, {1'b0, pc});
  endtask

  task automatic fchk(input logic r, input logic l);
    chk("repeat flag", {23'h0, r}, {23'h0, rep_act});
    chk("loop flag", {23'h0, l}, {23'h0, loop_act});
  endtask

  task automatic st(input logic [6:0] k, input logic [15:0] o,
                    input logic [23:0] t, input logic [7:0] sl);
    fe.issue({k, o, t, sl});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '{a, ~d, 1'b0, 1'b0};
    #1;
  endtask

  task automatic rchk2(input string n, input logic [3:0] a,
                       input logic [15:0] e, input logic [15:0] ex);
    @(posedge clk);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '{a, 16'hFFFF, 1'b0, 1'b0};
    #1;
    chk(n, {8'h0, e}, {8'h0, rdata});
    chk({n, " ext"}, {8'h0, ex}, {8'h0, rdata_x});
  endtask

  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [15:0] e);
    rchk2(n, a, e, e);
  endtask

  task automatic t_reset();
    pchk(23'h0);
    fchk(1'b0, 1'b0);
    rchk("status", STATUS_OFS, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_seq();
    st(K_BR, 16'h0, 24'h000100, 8'h0);
    for (int i = 1; i <= 3; i++) begin
      st(K_ST, 16'h0, 24'h0, 8'h0);
      pchk(23'h000100 + 23'(2 * i));
    end
    st(K_BR, 16'h0, 24'h000301, 8'h0);
    pchk(23'h000300);
    $display("test sequential done");
  endtask

  task automatic t_fault();
    st(K_BR, 16'h0, 24'h800000, 8'h0);
    pchk(23'h000300);
    chk("fault", 24'h1, {23'h0, fault});
    st(K_BR, 16'h0, 24'h7FFFFE, 8'h0);
    pchk(23'h7FFFFE);
    wr(CORE_OFS, 16'h0001);
    chk("fault", 24'h0, {23'h0, fault});
    $display("test fault done");
  endtask

  task automatic t_repeat();
    st(K_BR, 16'h0, 24'h000200, 8'h0);
    st(K_RP, 16'h0001, 24'h0, 8'h0);
    fchk(1'b1, 1'b0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000202);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000204);
    fchk(1'b0, 1'b0);
    st(K_RP | 7'h01, 16'hFFFF, 24'h0, 8'h0);
    rchk2("repeat count", REP_CNT_OFS, 16'h3FFF, 16'hFFFF);
    st(K_TR, 16'h0, 24'h000400, 8'h0);
    wr(REP_CNT_OFS, 16'h0000);
    st(K_RF, 16'h0, 24'h000206, 8'h10);
    fchk(1'b1, 1'b0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000208);
    fchk(1'b0, 1'b0);
    st(K_RP, 16'h0005, 24'h0, 8'h0);
    st(K_TR, 16'h0, 24'h000400, 8'h0);
    st(K_RF, 16'h0, 24'h00020A, 8'h00);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h00020C);
    fchk(1'b0, 1'b0);
    $display("test repeat done");
  endtask

  task automatic t_readonly();
    wr(STATUS_OFS, 16'hFFFF);
    rchk("status", STATUS_OFS, 16'h0000);
    fchk(1'b0, 1'b0);
    wr(START_L_OFS, 16'h0700);
    rchk2("loop start", START_L_OFS, 16'h0700, 16'h0000);
    $display("test read-only done");
  endtask

  task automatic t_loop();
    st(K_BR, 16'h0, 24'h000300, 8'h0);
    st(K_LP, 16'h0001, 24'h000304, 8'h0);
    fchk(1'b0, 1'b1);
    wr(STATUS_OFS, 16'h0000);
    fchk(1'b0, 1'b1);
    rchk("loop start", START_L_OFS, 16'h0302);
    rchk("loop end", END_L_OFS, 16'h0304);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000302);
    rchk("loop count", HWL_CNT_OFS, 16'h0000);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000306);
    fchk(1'b0, 1'b0);
    $display("test loop done");
  endtask

  task automatic t_nest();
    st(K_BR, 16'h0, 24'h000500, 8'h0);
    st(K_LP, 16'h0000, 24'h000508, 8'h0);
    st(K_LP | 7'h01, 16'hC002, 24'h000506, 8'h0);
    pchk(23'h000504);
    rchk2("loop count", HWL_CNT_OFS, 16'h0002, 16'hC002);
    rchk("core", CORE_OFS, 16'h0200);
    wr(CORE_OFS, 16'h0800);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000508);
    fchk(1'b0, 1'b1);
    rchk("core", CORE_OFS, 16'h0100);
    rchk("loop end", END_L_OFS, 16'h0508);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h00050A);
    fchk(1'b0, 1'b0);
    $display("test nesting done");
  endtask

  task automatic t_early_reset();
    st(K_BR, 16'h0, 24'h000600, 8'h0);
    st(K_LP, 16'h0003, 24'h000604, 8'h0);
    wr(CORE_OFS, 16'h0800);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    st(K_ST, 16'h0, 24'h0, 8'h0);
    pchk(23'h000606);
    fchk(1'b0, 1'b0);
    rchk("core", CORE_OFS, 16'h0000);
    st(K_LP, 16'h0002, 24'h00060A, 8'h0);
    st(K_RP, 16'h0004, 24'h0, 8'h0);
    fchk(1'b1, 1'b1);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    pchk(23'h0);
    fchk(1'b0, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    pchk(23'h0);
    fchk(1'b0, 1'b0);
    rchk("loop count", HWL_CNT_OFS, 16'h0000);
    $display("test early exit and reset done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    bus = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_seq();
    t_fault();
    t_repeat();
    t_readonly();
    t_loop();
    t_nest();
    t_early_reset();
    report_and_stop();
  end
endmodule
